/* File: arf_device.sv */
// Purpose: Receive FIFO control, byte count and transmit block length
// Assumes: Received characters arrive already deserialised
// Notes:   Characters are right aligned; parity beside them
// -----------------------------------------------------------------
// What this block does
// - Parity store disable drops parity bit
// - Parity always placed in status byte
// - Flow characters optionally discarded
// - Status byte follows data when enabled
// - Status: errors bit7 and 6, parity bit0
// - Parity sits above short characters
// - Threshold field selects pool size
// - Pool full interrupt at threshold
// - Host releases pool with release command after termination
// - Termination character match raises interrupt
// - Host reads low count after termination
// - Host masks count with threshold minus one
// - Release after termination clears count
// - Pool full adds threshold to count
// - Count high echoes DMA and auto-start
// - Upper count bits unused in async
// - Block length is twelve-bit value plus one
// - Exactly block-length DMA requests per frame
// - Host writes zero to unused FIFO control bits
// - Count high top bits zero after reset
// - Character length field decodes 8 to 5
// - Parity error in status byte MSB
// -----------------------------------------------------------------
`timescale 1ns/100ps
module arf_device
   import arf_pkg::*;
#(
   parameter int DEPTH = ARF_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // Received characters
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_char,
   input  wire logic       i_rx_parity,
   input  wire logic       i_rx_parity_err,
   input  wire logic       i_rx_frame_err,
   output logic            o_rx_ready,
   // Link
   arf_link_if.device      link
);
   initial begin
      if (DEPTH < 64 || (DEPTH & (DEPTH - 1)) != 0) $error("arf depth");
   end
   localparam int AW = $clog2(DEPTH);
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [5:0] thr_bytes(input logic [1:0] sel,
                                            input logic fmt);
      case (sel)
         2'b00:   thr_bytes = fmt ? 6'd2 : 6'd1;
         2'b01:   thr_bytes = 6'd4;
         2'b10:   thr_bytes = 6'd16;
         default: thr_bytes = 6'd32;
      endcase
   endfunction
   function automatic logic [3:0] char_len(input logic [1:0] sel);
      char_len = 4'd8 - {2'b00, sel};
   endfunction
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0]  fc_q, fc_d, tc_q, tc_d, df_q, df_d, xon_q, xon_d;
   logic [7:0]  xoff_q, xoff_d, xbl_q, xbl_d, xbh_q, xbh_d;
   logic [11:0] rcnt_q, rcnt_d, cnt_view;
   logic        term_seen_q, term_seen_d;
   logic [7:0]  rd_q, rd_d;
   logic        rv_q, rv_d, pirq_q, pirq_d, tirq_q, tirq_d;
   logic [12:0] dma_left_q, dma_left_d;
   logic        dreq_q, dreq_d;
   logic        stat_pend_q, stat_pend_d;
   logic [7:0]  stat_q, stat_d;
   logic [AW:0] fill_q, fill_d, pool_q, pool_d;
   logic [7:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   // -----------------------------------------------------------------
   // Character formatting
   // -----------------------------------------------------------------
   logic [3:0] clen;
   logic [7:0] dbyte, sbyte, cmask;
   logic       is_flow, keep, sk_ready, sk_valid;
   logic [10:0] sk_data;
   logic       wr_dat, wr_stat, dma_on, wr_go, rel, frame_go, fifo_rd;
   logic [5:0] thr;
   always_comb begin
      clen  = char_len(df_q[ARF_DF_CHL_LO +: 2]);
      cmask = 8'hff >> (4'd8 - clen);
      dbyte = i_rx_char & cmask;
      if (df_q[ARF_DF_PAR_EN] && clen < 4'd8 &&
          !fc_q[ARF_FC_PARITY_DIS]) begin
         dbyte = dbyte | (8'(i_rx_parity) << clen);
      end
      // Flags travel with their character through the buffer
      sbyte = 8'h00;
      sbyte[ARF_ST_PERR] = sk_data[8];
      sbyte[ARF_ST_FERR] = sk_data[10];
      sbyte[ARF_ST_PAR]  = sk_data[9];
      is_flow = (dbyte & cmask) == xon_q || (dbyte & cmask) == xoff_q;
      keep = !(fc_q[ARF_FC_FLOW_DIS] && is_flow);
   end
   // Flag bits ride above the data byte until written
   arf_skid #(.W(11)) u_skid (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_valid  (i_rx_valid && keep),
      .i_data   ({i_rx_frame_err, i_rx_parity, i_rx_parity_err, dbyte}),
      .o_ready  (sk_ready),
      .o_valid  (sk_valid),
      .o_data   (sk_data),
      .i_ready  (wr_go)
   );
   // -----------------------------------------------------------------
   // FIFO, counts and register port
   // -----------------------------------------------------------------
   always_comb begin
      fc_d = fc_q; tc_d = tc_q; df_d = df_q; xon_d = xon_q;
      xoff_d = xoff_q; xbl_d = xbl_q; xbh_d = xbh_q;
      rcnt_d = rcnt_q; term_seen_d = term_seen_q;
      rd_d = rd_q; rv_d = 1'b0; pirq_d = 1'b0; tirq_d = 1'b0;
      dma_left_d = dma_left_q; dreq_d = 1'b0;
      stat_pend_d = stat_pend_q; stat_d = stat_q;
      wp_d = wp_q; rp_d = rp_q; fill_d = fill_q; pool_d = pool_q;
      thr = thr_bytes(fc_q[ARF_FC_THR_LO +: 2], fc_q[ARF_FC_STATUS_FMT]);
      dma_on = xbh_q[ARF_CH_DMA];
      // Partial pool included so a masked count gives the tail
      cnt_view = rcnt_q + 12'(pool_q);
      // Room for data plus status keeps a pair in one pool
      wr_go  = !stat_pend_q && (fill_q < (AW+1)'(DEPTH) -
               (AW+1)'(fc_q[ARF_FC_STATUS_FMT]));
      wr_dat = sk_valid && wr_go;
      wr_stat = stat_pend_q;
      rel = link.wr_en && link.addr == ARF_OFS_COMMAND &&
            link.wdata[ARF_CMD_RELEASE];
      frame_go = link.wr_en && link.addr == ARF_OFS_COMMAND &&
            link.wdata[ARF_CMD_TX_FRAME];
      fifo_rd = link.rd_en && link.addr == ARF_OFS_FIFO_DATA &&
                fill_q != '0;
      if (wr_dat) begin
         wp_d = wp_q + 1'b1;
         if (fc_q[ARF_FC_STATUS_FMT]) begin
            stat_pend_d = 1'b1;
            stat_d = sbyte;
         end
         if (fc_q[ARF_FC_TERM_EN] && sk_data[7:0] == tc_q) begin
            tirq_d = 1'b1;
            term_seen_d = 1'b1;
         end
      end else if (wr_stat) begin
         wp_d = wp_q + 1'b1;
         stat_pend_d = 1'b0;
      end
      fill_d = fill_q + (AW+1)'(wr_dat || wr_stat) - (AW+1)'(fifo_rd);
      if (fifo_rd) begin
         rp_d = rp_q + 1'b1;
      end
      // Pool counts bytes written since last pool boundary
      pool_d = pool_q + (AW+1)'(wr_dat || wr_stat);
      if (pool_d >= (AW+1)'(thr) && !stat_pend_d) begin
         pirq_d = 1'b1;
         pool_d = '0;
         rcnt_d = rcnt_q + 12'(thr);
      end
      if (rel && term_seen_q) begin
         rcnt_d = 12'h000;
         term_seen_d = 1'b0;
         pool_d = '0;
      end
      if (link.wr_en) begin
         if (link.addr == ARF_OFS_COUNT_LOW) begin
            xbl_d = link.wdata;
         end else if (link.addr == ARF_OFS_COUNT_HIGH) begin
            xbh_d = link.wdata;
         end else if (link.addr == ARF_OFS_FIFO_CTRL) begin
            fc_d = link.wdata;
         end else if (link.addr == ARF_OFS_TERM_CHAR) begin
            tc_d = link.wdata;
         end else if (link.addr == ARF_OFS_FORMAT) begin
            df_d = link.wdata;
         end else if (link.addr == ARF_OFS_FLOW_CHARS) begin
            xon_d = link.wdata;
         end
      end
      if (link.rd_en) begin
         rv_d = 1'b1;
         if (link.addr == ARF_OFS_COUNT_LOW) begin
            rd_d = cnt_view[7:0];
         end else if (link.addr == ARF_OFS_COUNT_HIGH) begin
            rd_d = 8'h00;
            rd_d[ARF_CH_DMA] = xbh_q[ARF_CH_DMA];
            rd_d[ARF_CH_CAS] = xbh_q[ARF_CH_CAS];
         end else if (link.addr == ARF_OFS_FIFO_CTRL) begin
            rd_d = fc_q;
         end else if (link.addr == ARF_OFS_FIFO_DATA) begin
            rd_d = mem_q[rp_q];
         end else begin
            rd_d = 8'h00;
         end
      end
      // DMA block length xbc plus one
      if (frame_go && dma_on) begin
         dma_left_d = {1'b0, xbh_q[3:0], xbl_q} + 13'd1;
      end else if (dma_left_q != '0 && link.dma_ack && dreq_q) begin
         dma_left_d = dma_left_q - 13'd1;
      end
      dreq_d = dma_left_d != '0 && !(dreq_q && link.dma_ack);
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         fc_q <= ARF_RST_FIFO_CTRL; tc_q <= 8'h00;
         df_q <= ARF_RST_FORMAT; xon_q <= ARF_RST_XON;
         xoff_q <= ARF_RST_XOFF; xbl_q <= 8'h00;
         xbh_q <= 8'h00;
         rcnt_q <= 12'h000; term_seen_q <= 1'b0;
         rd_q <= 8'h00; rv_q <= 1'b0; pirq_q <= 1'b0; tirq_q <= 1'b0;
         dma_left_q <= '0; dreq_q <= 1'b0;
         stat_pend_q <= 1'b0; stat_q <= 8'h00;
         wp_q <= '0; rp_q <= '0; fill_q <= '0; pool_q <= '0;
      end else begin
         fc_q <= fc_d; tc_q <= tc_d; df_q <= df_d; xon_q <= xon_d;
         xoff_q <= xoff_d; xbl_q <= xbl_d; xbh_q <= xbh_d;
         rcnt_q <= rcnt_d; term_seen_q <= term_seen_d;
         rd_q <= rd_d; rv_q <= rv_d; pirq_q <= pirq_d; tirq_q <= tirq_d;
         dma_left_q <= dma_left_d; dreq_q <= dreq_d;
         stat_pend_q <= stat_pend_d; stat_q <= stat_d;
         wp_q <= wp_d; rp_q <= rp_d; fill_q <= fill_d; pool_q <= pool_d;
      end
      if (wr_dat) begin
         mem_q[wp_q] <= sk_data[7:0];
      end else if (wr_stat) begin
         mem_q[wp_q] <= stat_q;
      end
   end
   assign o_rx_ready         = sk_ready;
   assign link.rdata         = rd_q;
   assign link.rvalid        = rv_q;
   assign link.pool_full_irq = pirq_q;
   assign link.term_irq      = tirq_q;
   assign link.dma_req       = dreq_q;
endmodule

/* File: arf_pkg.sv */
// Purpose: Shared constants for the receive FIFO control block
// Assumes: One channel, asynchronous mode, one 20 MHz clock
// Notes:   Register offsets are byte addresses on the register port
package arf_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ARF_OFS_COUNT_LOW  = 8'h2a;
   localparam logic [7:0] ARF_OFS_COUNT_HIGH = 8'h2b;
   localparam logic [7:0] ARF_OFS_FIFO_CTRL  = 8'h2c;
   localparam logic [7:0] ARF_OFS_TERM_CHAR  = 8'h2d;
   localparam logic [7:0] ARF_OFS_FORMAT     = 8'h2e;
   localparam logic [7:0] ARF_OFS_FLOW_CHARS = 8'h2f;
   localparam logic [7:0] ARF_OFS_FIFO_DATA  = 8'h30;
   localparam logic [7:0] ARF_OFS_COMMAND    = 8'h31;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int ARF_FC_PARITY_DIS = 0;
   localparam int ARF_FC_FLOW_DIS   = 1;
   localparam int ARF_FC_STATUS_FMT = 2;
   localparam int ARF_FC_THR_LO     = 3;
   localparam int ARF_FC_TERM_EN    = 5;
   localparam int ARF_DF_CHL_LO     = 0;
   localparam int ARF_DF_PAR_EN     = 2;
   localparam int ARF_CH_DMA        = 7;
   localparam int ARF_CH_CAS        = 5;
   localparam int ARF_CH_CONT       = 4;
   localparam int ARF_ST_PERR       = 7;
   localparam int ARF_ST_FERR       = 6;
   localparam int ARF_ST_PAR        = 0;
   localparam int ARF_CMD_RELEASE   = 0;
   localparam int ARF_CMD_TX_FRAME  = 1;
   // -----------------------------------------------------------------
   // Reset values and depths
   // -----------------------------------------------------------------
   localparam logic [7:0] ARF_RST_FIFO_CTRL = 8'h00;
   localparam logic [7:0] ARF_RST_FORMAT    = 8'h00;
   localparam logic [7:0] ARF_RST_XON       = 8'h11;
   localparam logic [7:0] ARF_RST_XOFF      = 8'h13;
   localparam int         ARF_FIFO_DEPTH    = 64;
   localparam int         ARF_SKID_DEPTH    = 2;
endpackage

/* File: arf_link_if.sv */
// Purpose: Carrier between the receive device end and the host end
// Assumes: Single clock, host drives register strobes
// Notes:   Read data valid one cycle after a read strobe
`timescale 1ns/100ps
interface arf_link_if;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvalid;
   logic       pool_full_irq;
   logic       term_irq;
   logic       dma_req;
   logic       dma_ack;
   modport device (
      input  wr_en, rd_en, addr, wdata, dma_ack,
      output rdata, rvalid, pool_full_irq, term_irq, dma_req
   );
   modport host (
      output wr_en, rd_en, addr, wdata, dma_ack,
      input  rdata, rvalid, pool_full_irq, term_irq, dma_req
   );
endinterface

/* File: arf_skid.sv */
// Purpose: Two-entry buffer between receiver and FIFO write port
// Assumes: Single clock
// Notes:   Full registered ready; no bubble at steady flow
`timescale 1ns/100ps
module arf_skid #(
   parameter int W = 9
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // Upstream
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_data,
   output logic              o_ready,
   // Downstream
   output logic              o_valid,
   output logic [W-1:0]      o_data,
   input  wire logic         i_ready
);
   initial begin
      if (W < 1) $error("arf_skid width");
   end
   logic [W-1:0] mem_q [2];
   logic [W-1:0] mem_d [2];
   logic [1:0]   cnt_q, cnt_d;
   logic         rdy_q;
   logic         push, pop;
   always_comb begin
      push     = i_valid && (cnt_q != 2'd2);
      pop      = i_ready && (cnt_q != 2'd0);
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      cnt_d    = cnt_q;
      if (pop) begin
         mem_d[0] = mem_q[1];
      end
      if (push) begin
         mem_d[(cnt_q == 2'd0 || (pop && cnt_q == 2'd1)) ? 0 :
               (pop ? 0 : 1)] = i_data;
         if (pop && cnt_q == 2'd2) begin
            mem_d[1] = i_data;
         end
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_q <= 2'd0;
         rdy_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         rdy_q <= (cnt_d != 2'd2);
      end
      mem_q <= mem_d;
   end
   assign o_ready = rdy_q;
   assign o_valid = (cnt_q != 2'd0);
   assign o_data  = mem_q[0];
endmodule

/* File: arf_host.sv */
// Purpose: Host end driving register port, releasing pools
// Assumes: User side issues simple read and write requests
// Notes:   One request in flight; writes answer one cycle later, reads three cycles later
`timescale 1ns/100ps
module arf_host
   import arf_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // User request
   input  wire logic       i_req,
   input  wire logic       i_we,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic            o_done,
   output logic            o_pool_irq,
   output logic            o_term_irq,
   // Link
   arf_link_if.host        link
);
   logic       wr_q, wr_d, rd_q, rd_d, done_q, done_d;
   logic [7:0] a_q, a_d, w_q, w_d, r_q, r_d;
   logic       pi_q, ti_q;
   always_comb begin
      wr_d   = 1'b0;
      rd_d   = 1'b0;
      a_d    = a_q;
      w_d    = w_q;
      r_d    = r_q;
      done_d = 1'b0;
      if (i_req) begin
         wr_d = i_we;
         rd_d = !i_we;
         a_d  = i_addr;
         w_d  = (i_addr == ARF_OFS_FIFO_CTRL) ? (i_wdata & 8'h3f) : i_wdata;
         done_d = i_we;
      end
      if (link.rvalid) begin
         r_d    = link.rdata;
         done_d = 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         a_q <= 8'h00;
         w_q <= 8'h00;
         r_q <= 8'h00;
         done_q <= 1'b0;
         pi_q <= 1'b0;
         ti_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         a_q <= a_d;
         w_q <= w_d;
         r_q <= r_d;
         done_q <= done_d;
         pi_q <= link.pool_full_irq;
         ti_q <= link.term_irq;
      end
   end
   assign link.wr_en   = wr_q;
   assign link.rd_en   = rd_q;
   assign link.addr    = a_q;
   assign link.wdata   = w_q;
   assign link.dma_ack = link.dma_req;
   assign o_rdata      = r_q;
   assign o_done       = done_q;
   assign o_pool_irq   = pi_q;
   assign o_term_irq   = ti_q;
endmodule

/* File: arf_link_checker.sv */
// Purpose: Link checks between the device and host ends
// Assumes: One clock, synchronous active-low reset
// Notes:   Shadows host writes to judge read-back and DMA counts
`timescale 1ns/100ps
module arf_link_checker
   import arf_pkg::*;
(
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_resetn,
   // Link signals
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   input wire logic       pool_full_irq,
   input wire logic       term_irq,
   input wire logic       dma_req,
   input wire logic       dma_ack
);
   // ---------------------------------------------------------------
   // Shadow registers
   // ---------------------------------------------------------------
   logic [7:0]  ctrl_q, ctrl_d, mode_q, mode_d;
   logic [11:0] len_q, len_d;
   logic [12:0] dcnt_q, dcnt_d;
   always_comb begin
      ctrl_d = ctrl_q;
      mode_d = mode_q;
      len_d  = len_q;
      dcnt_d = dcnt_q;
      if (wr_en && addr == ARF_OFS_FIFO_CTRL) begin
         ctrl_d = wdata;
      end
      if (wr_en && addr == ARF_OFS_COUNT_HIGH) begin
         mode_d      = wdata;
         len_d[11:8] = wdata[3:0];
      end
      if (wr_en && addr == ARF_OFS_COUNT_LOW) begin
         len_d[7:0] = wdata;
      end
      if (wr_en && addr == ARF_OFS_COMMAND && wdata[ARF_CMD_TX_FRAME]) begin
         dcnt_d = 13'h0;
      end else if (dma_req && dma_ack) begin
         dcnt_d = dcnt_q + 13'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         ctrl_q <= 8'h00;
         mode_q <= 8'h00;
         len_q  <= 12'h000;
         dcnt_q <= 13'h0;
      end else begin
         ctrl_q <= ctrl_d;
         mode_q <= mode_d;
         len_q  <= len_d;
         dcnt_q <= dcnt_d;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   read_answer_a: assert property (rd_en |=> rvalid)
      else $error("read strobe got no answer");
   answer_cause_a: assert property (rvalid |-> $past(rd_en))
      else $error("answer without a read strobe");
   data_hold_a: assert property (!rvalid |-> $stable(rdata))
      else $error("read data moved without an answer");
   mode_echo_a: assert property (rd_en && addr == ARF_OFS_COUNT_HIGH |=>
      !rdata[6] && !rdata[4] && rdata[7] == mode_q[7]
      && rdata[5] == mode_q[5]) else $error("count high read-back wrong");
   unmapped_zero_a: assert property (rd_en && (addr < ARF_OFS_COUNT_LOW
      || addr > ARF_OFS_COMMAND) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   term_enable_a: assert property (term_irq |->
      $past(ctrl_q[ARF_FC_TERM_EN]))
      else $error("termination interrupt while disabled");
   dma_bound_a: assert property (dcnt_q <= {1'b0, len_q} + 13'h1)
      else $error("more transfer requests than block length");
   dma_mode_a: assert property (dma_req |-> mode_q[ARF_CH_DMA])
      else $error("transfer request outside DMA mode");
   pool_pulse_a: assert property (pool_full_irq |=> !pool_full_irq)
      else $error("pool interrupt longer than one cycle");
   reset_quiet_a: assert property ($rose(i_resetn) |-> !rvalid
      && !pool_full_irq && !term_irq && !dma_req)
      else $error("outputs active after reset");
endmodule

/* File: tb_async_rx_fifo_and_byte_count.sv */
// Purpose: Self-checking bench for both ends across the link
// Assumes: Host end ties DMA acknowledge to request
// Notes:   Fill test relies on the receiver refusing when full
`timescale 1ns/100ps
module tb_async_rx_fifo_and_byte_count;
   import arf_pkg::*;
   typedef struct {
      logic [7:0] fmt, ctl, ch, dat, st;
      logic       p, perr, ferr;
   } arf_row_s;
   logic       i_clk = 1'b0;
   logic       i_resetn = 1'b0;
   logic       i_rx_valid = 1'b0;
   logic [7:0] i_rx_char = 8'h00;
   logic       i_rx_parity = 1'b0;
   logic       i_rx_parity_err = 1'b0;
   logic       i_rx_frame_err = 1'b0;
   logic       i_req = 1'b0;
   logic       i_we = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] o_rdata, rd;
   logic       o_rx_ready, o_done, o_pool_irq, o_term_irq, ok, refused;
   int         err_count = 0;
   int         n_tests = 0;
   int         pool_cnt = 0;
   int         term_cnt = 0;
   int         dma_cnt = 0;
   int         n, acc;
   logic [7:0] dhi[3] = '{8'h80, 8'ha0, 8'h81};
   logic [7:0] dlo[3] = '{8'h00, 8'h04, 8'h00};
   int         dexp[3] = '{1, 5, 257};
   // Fields: format, control, char, data, status, parity, errors
   arf_row_s   rows[8] = '{
      '{8'h04, 8'h04, 8'ha5, 8'ha5, 8'h81, 1'b1, 1'b1, 1'b0},
      '{8'h05, 8'h00, 8'h35, 8'hb5, 8'h00, 1'b1, 1'b0, 1'b0},
      '{8'h05, 8'h01, 8'h35, 8'h35, 8'h00, 1'b1, 1'b0, 1'b0},
      '{8'h06, 8'h05, 8'h2a, 8'h2a, 8'h41, 1'b1, 1'b0, 1'b1},
      '{8'h07, 8'h00, 8'h15, 8'h35, 8'h00, 1'b1, 1'b0, 1'b0},
      '{8'h00, 8'h00, 8'h3c, 8'h3c, 8'h00, 1'b1, 1'b0, 1'b0},
      '{8'h00, 8'h00, 8'h13, 8'h13, 8'h00, 1'b0, 1'b0, 1'b0},
      '{8'h05, 8'h04, 8'h35, 8'hb5, 8'h01, 1'b1, 1'b0, 1'b0}};
   always #25 i_clk = ~i_clk;
   arf_link_if link ();
   arf_device u_arf_device (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char),
      .i_rx_parity(i_rx_parity), .i_rx_parity_err(i_rx_parity_err),
      .i_rx_frame_err(i_rx_frame_err), .o_rx_ready(o_rx_ready), .link(link));
   arf_host u_arf_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(i_req),
      .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .o_done(o_done), .o_pool_irq(o_pool_irq), .o_term_irq(o_term_irq),
      .link(link));
   arf_link_checker u_arf_link_checker (.i_clk(i_clk), .i_resetn(i_resetn),
      .wr_en(link.wr_en), .rd_en(link.rd_en), .addr(link.addr),
      .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
      .pool_full_irq(link.pool_full_irq), .term_irq(link.term_irq),
      .dma_req(link.dma_req), .dma_ack(link.dma_ack));
   always @(posedge i_clk) begin
      if (o_pool_irq === 1'b1) pool_cnt++;
      if (o_term_irq === 1'b1) term_cnt++;
      if (link.dma_req === 1'b1 && link.dma_ack === 1'b1) dma_cnt++;
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic hop(input logic we, input logic [7:0] a, wd);
      int k;
      @(posedge i_clk);
      i_req   <= 1'b1;
      i_we    <= we;
      i_addr  <= a;
      i_wdata <= wd;
      @(posedge i_clk);
      i_req <= 1'b0;
      k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (o_done !== 1'b1 && k < 20);
      rd = o_rdata;
      if (k >= 20) chk(16'h0, 16'h1, "no completion");
   endtask
   task automatic snd(input logic [7:0] c, input logic p, perr, ferr);
      int k;
      @(posedge i_clk);
      i_rx_valid      <= 1'b1;
      i_rx_char       <= c;
      i_rx_parity     <= p;
      i_rx_parity_err <= perr;
      i_rx_frame_err  <= ferr;
      ok = 1'b0;
      for (k = 0; k < 30 && !ok; k++) begin
         @(negedge i_clk);
         ok = (o_rx_ready === 1'b1);
         @(posedge i_clk);
      end
      i_rx_valid <= 1'b0;
      i_rx_char  <= ~c;
   endtask
   task automatic wirq(input logic t, input int target);
      int k;
      k = 0;
      while ((t ? term_cnt : pool_cnt) < target && k < 60) begin
         @(negedge i_clk);
         k++;
      end
   endtask
   task automatic rdchk(input int cnt, input logic [7:0] base);
      for (int j = 0; j < cnt; j++) begin
         hop(1'b0, ARF_OFS_FIFO_DATA, 8'h00);
         chk(16'(rd), 16'(base + 8'(j)), "fifo byte");
      end
   endtask
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      hop(1'b0, ARF_OFS_COUNT_HIGH, 8'h00);
      chk(16'(rd & 8'he0), 16'h0, "count high after reset");
      hop(1'b0, 8'h50, 8'h00);
      chk(16'(rd), 16'h0, "unmapped read");
      $display("test reset done");
      hop(1'b1, ARF_OFS_FORMAT, 8'h00);
      hop(1'b1, ARF_OFS_TERM_CHAR, 8'h0d);
      hop(1'b1, ARF_OFS_FIFO_CTRL, 8'h28);
      for (n = 1; n <= 4; n++) snd(8'(n), 1'b0, 1'b0, 1'b0);
      wirq(1'b0, 1);
      hop(1'b0, ARF_OFS_COUNT_LOW, 8'h00);
      chk(16'(rd), 16'h4, "count after pool");
      rdchk(4, 8'h01);
      hop(1'b1, ARF_OFS_COMMAND, 8'h01);
      snd(8'h05, 1'b0, 1'b0, 1'b0);
      snd(8'h06, 1'b0, 1'b0, 1'b0);
      snd(8'h0d, 1'b0, 1'b0, 1'b0);
      wirq(1'b1, 1);
      chk(16'(term_cnt), 16'h1, "termination interrupt");
      hop(1'b0, ARF_OFS_COUNT_LOW, 8'h00);
      chk(16'(rd & 8'h03), 16'h3, "masked count");
      rdchk(2, 8'h05);
      rdchk(1, 8'h0d);
      hop(1'b1, ARF_OFS_COMMAND, 8'h01);
      hop(1'b0, ARF_OFS_COUNT_LOW, 8'h00);
      chk(16'(rd), 16'h0, "count cleared");
      $display("test termination done");
      hop(1'b1, ARF_OFS_FIFO_CTRL, 8'h02);
      n = pool_cnt;
      snd(8'h11, 1'b0, 1'b0, 1'b0);
      snd(8'h13, 1'b0, 1'b0, 1'b0);
      snd(8'h42, 1'b0, 1'b0, 1'b0);
      wirq(1'b0, n + 2);
      chk(16'(pool_cnt - n), 16'h1, "flow chars discarded");
      rdchk(1, 8'h42);
      hop(1'b1, ARF_OFS_COMMAND, 8'h01);
      $display("test flow chars done");
      foreach (rows[i]) begin
         hop(1'b1, ARF_OFS_FORMAT, rows[i].fmt);
         hop(1'b1, ARF_OFS_FIFO_CTRL, rows[i].ctl);
         n = pool_cnt;
         snd(rows[i].ch, rows[i].p, rows[i].perr, rows[i].ferr);
         wirq(1'b0, n + 1);
         chk(16'(pool_cnt - n), 16'h1, "pool per character");
         rdchk(1, rows[i].dat);
         if (rows[i].ctl[ARF_FC_STATUS_FMT]) begin
            rdchk(1, rows[i].st);
         end
         hop(1'b1, ARF_OFS_COMMAND, 8'h01);
         $display("test row %0d done", i);
      end
      foreach (dexp[i]) begin
         hop(1'b1, ARF_OFS_COUNT_HIGH, dhi[i]);
         hop(1'b1, ARF_OFS_COUNT_LOW, dlo[i]);
         hop(1'b0, ARF_OFS_COUNT_HIGH, 8'h00);
         chk(16'(rd & 8'hf0), 16'(dhi[i] & 8'ha0), "mode echo");
         n = dma_cnt;
         hop(1'b1, ARF_OFS_COMMAND, 8'h02);
         for (acc = 0; acc < 900 && dma_cnt - n < dexp[i]; acc++) begin
            @(negedge i_clk);
         end
         repeat (20) @(negedge i_clk);
         chk(16'(dma_cnt - n), 16'(dexp[i]), "transfer requests");
         $display("test block length %0d done", dexp[i]);
      end
      hop(1'b1, ARF_OFS_FORMAT, 8'h00);
      hop(1'b1, ARF_OFS_FIFO_CTRL, 8'h18);
      n = pool_cnt;
      refused = 1'b0;
      for (acc = 0; acc < 70; acc++) begin
         snd(8'h40 + acc[7:0], 1'b0, 1'b0, 1'b0);
         if (!ok) refused = 1'b1;
      end
      chk(16'(refused), 16'h1, "receiver refused when full");
      chk(16'(pool_cnt - n), 16'h2, "pools while full");
      rdchk(64, 8'h40);
      hop(1'b1, ARF_OFS_COMMAND, 8'h01);
      hop(1'b1, ARF_OFS_COMMAND, 8'h01);
      snd(8'h55, 1'b0, 1'b0, 1'b0);
      chk(16'(ok), 16'h1, "receiver takes data after drain");
      $display("test fill and drain done");
      results();
   end
endmodule
